/* logic/clh_host.sv */
// Host controller driving a character display over its parallel bus.
// Assumes the display pins are synchronised here; software uses a plain port.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module clh_host
  import clh_pkg::*;
#(
  parameter int POWER_CYC = CYC_POWER,
  parameter int SHORT_CYC = CYC_SHORT,
  parameter int LONG_CYC  = CYC_LONG
)
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Software port
  input  wire logic [3:0] regAddr,
  input  wire logic [9:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output      logic [9:0] regRdData,
  // Display pins
  output      clh_pins_t  lcdPins,
  input  wire logic [7:0] byteBusIn
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SETUP = 3'b001,
    S_HIGH  = 3'b011,
    S_LOW   = 3'b010,
    S_WAIT  = 3'b110
  } clh_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Registers

  clh_state_t         state_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [2:0]         initStep_q;
  logic               initDone_q;
  clh_cmd_t           cur_q;
  clh_cmd_t           pend_q;
  logic               pendValid_q;
  logic [7:0]         rdByte_q;
  logic               rdValid_q;
  logic [7:0]         config_q;
  logic [7:0]         busSync1_q;
  logic [7:0]         busSync2_q;
  logic [9:0]         regRdData_q;
  logic               lastWasRead_q;
  logic [7:0]         tableByte;
  logic [7:0]         tableWr_q;
  logic [7:0]         tableRd_q;

  //////////////////////////////////////////////////////////////////////////
  // Input synchroniser for the byte bus

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busSync1_q <= 8'h00;
      busSync2_q <= 8'h00;
    end
    else
    begin
      busSync1_q <= byteBusIn;
      busSync2_q <= busSync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Power-up sequence table, first two entries follow config bits

  function automatic clh_cmd_t initCmd(input logic [2:0] step,
                                       input logic [7:0] cfg);
    clh_cmd_t c;
    c = '{isRead: 1'b0, regSelect: 1'b0, payload: 8'h00};
    unique case (step)
      // Font bit shares bit 2 with display-on, so 5x8 stays fixed
      3'd0: c.payload = OP_FUNC | (cfg & (FUNC_8BIT | FUNC_2LINE));
      3'd1: c.payload = OP_DISPCTL | (cfg & (CTL_DISP | CTL_CURSOR
                                             | CTL_BLINK));
      3'd2: c.payload = OP_CLEAR;
      default: c.payload = OP_ENTRY | ENTRY_INC;
    endcase
    return c;
  endfunction

  // Long-running instructions need the long wait
  // clear and home take the long time
  function automatic logic isLong(input clh_cmd_t c);
    return !c.isRead && !c.regSelect && (c.payload[7:2] == 6'h00)
           && (c.payload[1:0] != 2'b00);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Software command intake

  logic cmdTake;
  logic startInit;
  logic startCmd;
  assign startInit = (state_q == S_IDLE) && !initDone_q
                     && (cnt_q == '0);
  assign startCmd  = (state_q == S_IDLE) && initDone_q && pendValid_q;
  assign cmdTake   = regWrite && (regAddr == ADR_CMD) && !pendValid_q;

  // Pending command slot, one deep
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_q      <= '0;
      pendValid_q <= 1'b0;
    end
    else if (cmdTake)
    begin
      pend_q      <= clh_cmd_t'(regWrData);
      pendValid_q <= 1'b1;
    end
    else if (startCmd)
    begin
      pendValid_q <= 1'b0;
    end
  end

  // Configuration bits for the start-up sequence
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      config_q <= CONFIG_RST;
    end
    else if (regWrite && regAddr == ADR_CONFIG)
    begin
      config_q <= regWrData[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus cycle state machine

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q    <= S_IDLE;
      cnt_q      <= CNT_W'(POWER_CYC - 1);
      initStep_q <= 3'd0;
      initDone_q <= 1'b0;
      cur_q      <= '0;
    end
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          if (cnt_q != '0)
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
          else if (startInit)
          begin
            cur_q   <= initCmd(initStep_q, config_q);
            cnt_q   <= CNT_W'(CYC_SETUP - 1);
            state_q <= S_SETUP;
          end
          else if (startCmd)
          begin
            cur_q   <= pend_q;
            cnt_q   <= CNT_W'(CYC_SETUP - 1);
            state_q <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          if (cnt_q != '0)
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
          else
          begin
            cnt_q   <= CNT_W'(CYC_HIGH - 1);
            state_q <= S_HIGH;
          end
        end
        S_HIGH:
        begin
          if (cnt_q != '0)
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
          else
          begin
            cnt_q   <= CNT_W'(CYC_LOW - 1);
            state_q <= S_LOW;
          end
        end
        S_LOW:
        begin
          if (cnt_q != '0)
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
          // execution wait before the next command, except after a busy-flag read
          else if (isLong(cur_q))
          begin
            cnt_q   <= CNT_W'(LONG_CYC - 1);
            state_q <= S_WAIT;
          end
          else if (cur_q.isRead && !cur_q.regSelect)
          begin
            state_q <= S_IDLE;
          end
          else
          begin
            cnt_q   <= CNT_W'(SHORT_CYC - 1);
            state_q <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (cnt_q != '0)
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
          else
          begin
            state_q <= S_IDLE;
            if (!initDone_q)
            begin
              // entry mode ends the start-up sequence
              initStep_q <= initStep_q + 3'd1;
              initDone_q <= (initStep_q == 3'd3);
            end
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read capture just before the strobe falls

  // sample data while strobe is high
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdByte_q      <= 8'h00;
      rdValid_q     <= 1'b0;
      lastWasRead_q <= 1'b0;
    end
    else if (state_q == S_HIGH && cnt_q == '0 && cur_q.isRead)
    begin
      rdByte_q      <= busSync2_q;
      rdValid_q     <= 1'b1;
      lastWasRead_q <= 1'b1;
    end
    else if (regRead && regAddr == ADR_RDDATA)
    begin
      rdValid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shadow of written characters, addressed by write and read pointers that step on each table write and each table read

  assign tableByte = regWrData[7:0];

  // Table write pointer follows software writes
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tableWr_q <= 8'h00;
    end
    else if (regWrite && regAddr == ADR_TABLE)
    begin
      tableWr_q <= tableWr_q + 8'h01;
    end
  end

  // Look one entry ahead during a read so back-to-back reads keep up
  logic       tableRead;
  logic [4:0] tableRdAddr;
  assign tableRead   = regRead && regAddr == ADR_TABLE;
  assign tableRdAddr = tableRead ? tableRd_q[4:0] + 5'h01 : tableRd_q[4:0];

  // Table read pointer steps on each table read
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tableRd_q <= 8'h00;
    end
    else if (tableRead)
    begin
      tableRd_q <= tableRd_q + 8'h01;
    end
  end

  logic [7:0] shadowRd;
  clh_line_mem #(.DEPTH(32)) uMem
  (
    .sys_clk (sys_clk),
    .wrEn    (regWrite && regAddr == ADR_TABLE),
    .wrAddr  (tableWr_q[4:0]),
    .wrData  (tableByte),
    .rdAddr  (tableRdAddr),
    .rdData  (shadowRd)
  );

  //////////////////////////////////////////////////////////////////////////
  // Software read data, one cycle after the strobe

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regRdData_q <= 10'h000;
    end
    else if (regRead)
    begin
      unique case (regAddr)
        ADR_STATUS: regRdData_q <= {6'h00,
                                    rdByte_q[BUSY_BIT] && lastWasRead_q,
                                    rdValid_q, !initDone_q,
                                    (state_q == S_IDLE) && !pendValid_q
                                    && initDone_q};
        ADR_RDDATA: regRdData_q <= {2'b00, rdByte_q};
        ADR_CONFIG: regRdData_q <= {2'b00, config_q};
        ADR_TABLE:  regRdData_q <= {2'b00, shadowRd};
        default:    regRdData_q <= 10'h000;
      endcase
    end
    else
    begin
      regRdData_q <= 10'h000;
    end
  end

  assign regRdData = regRdData_q;

  //////////////////////////////////////////////////////////////////////////
  // Pin drive

  always_comb
  begin
    lcdPins.regSelect    = cur_q.regSelect && (state_q != S_IDLE);
    lcdPins.readNotWrite = cur_q.isRead && (state_q != S_IDLE);
    lcdPins.strobe       = (state_q == S_HIGH);
    lcdPins.byteBusOut   = cur_q.payload;
    lcdPins.byteBusOe    = !cur_q.isRead && (state_q != S_IDLE)
                           && (state_q != S_WAIT);
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence strobeEnds_s;
    (state_q == S_HIGH) ##1 (state_q == S_LOW);
  endsequence

  dir_safe_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lcdPins.readNotWrite |-> !lcdPins.byteBusOe)
    else $error("Host drives bus during read");

  strobe_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(lcdPins.strobe) |-> lcdPins.strobe [*8])
    else $error("Strobe high too short");

  wr_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    strobeEnds_s |-> lcdPins.byteBusOe || cur_q.isRead)
    else $error("Write data lost at strobe fall");

  init_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(lcdPins.strobe) && initStep_q == 3'd0 && !initDone_q
    |-> lcdPins.byteBusOut[5])
    else $error("First command is not function set");

  short_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(state_q == S_WAIT) && !isLong(cur_q)
    |-> cnt_q == CNT_W'(SHORT_CYC-1))
    else $error("Short wait miscounted");

  long_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(state_q == S_WAIT) && isLong(cur_q) |-> cnt_q == CNT_W'(LONG_CYC-1))
    else $error("Long wait miscounted");

  rs_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lcdPins.strobe |-> $stable(lcdPins.regSelect))
    else $error("Register select moved under strobe");

  no_strobe_wait_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    state_q == S_WAIT |-> !lcdPins.strobe && !lcdPins.byteBusOe)
    else $error("Bus active during execution wait");

endmodule

/* logic/clh_pkg.sv */
// Constants, types and command codes for the character display host.
// Assumes a 100 MHz system clock and a display on an 8-bit parallel bus.
package clh_pkg;

  // Clock and timing figures
  localparam int CLK_MHZ      = 100;
  localparam int T_POWER_US   = 20000;
  localparam int T_SHORT_NS   = 37000;
  localparam int T_LONG_NS    = 1520000;
  localparam int CYC_POWER    = T_POWER_US * CLK_MHZ;
  localparam int CYC_SHORT    = (T_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_LONG     = (T_LONG_NS * CLK_MHZ + 999) / 1000;
  // Strobe phase lengths, setup 100 ns, high 500 ns, low 700 ns
  localparam int T_SETUP_NS   = 100;
  localparam int T_HIGH_NS    = 500;
  localparam int T_LOW_NS     = 700;
  localparam int CYC_SETUP    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_HIGH     = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_LOW      = (T_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 22;

  // Instruction codes and field bits
  localparam logic [7:0] OP_CLEAR    = 8'h01;
  localparam logic [7:0] OP_HOME     = 8'h02;
  localparam logic [7:0] OP_ENTRY    = 8'h04;
  localparam logic [7:0] OP_DISPCTL  = 8'h08;
  localparam logic [7:0] OP_SHIFT    = 8'h10;
  localparam logic [7:0] OP_FUNC     = 8'h20;
  localparam logic [7:0] OP_GLYPHADR = 8'h40;
  localparam logic [7:0] OP_DISPADR  = 8'h80;
  localparam logic [7:0] FUNC_8BIT   = 8'h10;
  localparam logic [7:0] FUNC_2LINE  = 8'h08;
  localparam logic [7:0] FUNC_FONT   = 8'h04;
  localparam logic [7:0] ENTRY_INC   = 8'h02;
  localparam logic [7:0] ENTRY_SHIFT = 8'h01;
  localparam logic [7:0] CTL_DISP    = 8'h04;
  localparam logic [7:0] CTL_CURSOR  = 8'h02;
  localparam logic [7:0] CTL_BLINK   = 8'h01;
  localparam logic [7:0] SHIFT_DISP  = 8'h08;
  localparam logic [7:0] SHIFT_RIGHT = 8'h04;
  localparam int         BUSY_BIT    = 7;
  localparam logic [6:0] ROW0_BASE   = 7'h00;
  localparam logic [6:0] ROW1_BASE   = 7'h40;
  localparam logic [6:0] ROW_LAST    = 7'h27;

  // Register map of the host's own command port
  localparam logic [3:0] ADR_CMD     = 4'h0;
  localparam logic [3:0] ADR_STATUS  = 4'h1;
  localparam logic [3:0] ADR_RDDATA  = 4'h2;
  localparam logic [3:0] ADR_CONFIG  = 4'h3;
  localparam logic [3:0] ADR_TABLE   = 4'h4;
  localparam logic [7:0] CONFIG_RST  = 8'h1c;
  localparam int         ST_READY    = 0;
  localparam int         ST_INIT     = 1;
  localparam int         ST_RDVALID  = 2;
  localparam int         ST_BUSYPOLL = 3;

  // Command word layout, bit 9 read, bit 8 register select, 7..0 byte
  typedef struct packed {
    logic       isRead;
    logic       regSelect;
    logic [7:0] payload;
  } clh_cmd_t;

  // Pins toward the display
  typedef struct packed {
    logic       regSelect;
    logic       readNotWrite;
    logic       strobe;
    logic [7:0] byteBusOut;
    logic       byteBusOe;
  } clh_pins_t;

endpackage

/* logic/clh_line_mem.sv */
// Byte table of DEPTH entries as last written by software.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/100ps
module clh_line_mem
  import clh_pkg::*;
#(
  parameter int DEPTH = 32
)
(
  // Clock
  input  wire logic                     sys_clk,
  // Write side
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [7:0]               wrData,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output      logic [7:0]               rdData
);

  logic [7:0] mem [DEPTH];

  // Store and registered read
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

/* tb/clh_lcd_model.sv */
// Behavioural character display answering the host's parallel bus.
// Assumes the host's pin struct; the clock samples the bus and measures execution times.
`timescale 1ns/100ps
module clh_lcd_model
  import clh_pkg::*;
#(
  parameter int POWER_CYC = 200,
  parameter int SHORT_CYC = 20,
  parameter int LONG_CYC  = 50
)
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Bus from the host
  input  wire clh_pins_t  lcdPins,
  output      logic [7:0] byteBusIn
);
  logic [7:0] dispMem [128];
  logic [7:0] glyphMem [64];
  logic [7:0] initLog [4];
  logic [7:0] outByte, ctlReg, funcReg, b;
  logic [6:0] addrCnt;
  logic       selGlyph, incMode, shiftEntry, stbOld, rsOld, rwOld, busyRd;
  int         busyCnt, upCnt, ofs, instCnt, errCnt;

  ////////////////////////////////////////////////////////////////////////////
  // Next address; display rows joined end to end
  function automatic logic [6:0] stepAdr(logic [6:0] a, logic up, logic g);
    if (g)
      return {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
    if (up)
      return (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : a + 7'h01;
    return (a == 7'h40) ? 7'h27 : (a == 7'h00) ? 7'h67 : a - 7'h01;
  endfunction

  function automatic logic [7:0] shown(int row, int col);
    return dispMem[(row != 0 ? 64 : 0) + (col + ofs + 400) % 40];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bytes only while strobe high on reads, else the inverted byte
  assign byteBusIn = (lcdPins.strobe && lcdPins.readNotWrite) ? outByte
                                                             : ~outByte;

  // Bus decoding and execution timing
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addrCnt = 7'h00;
      selGlyph = 1'b0;
      incMode = 1'b1;
      shiftEntry = 1'b0;
      stbOld = 1'b0;
      outByte = 8'h00;
      busyCnt = 0;
      upCnt = 0;
      ofs = 0;
      instCnt = 0;
      errCnt = 0;
    end
    else
    begin
      upCnt++;
      if (busyCnt > 0)
        busyCnt--;
      // host released bus, selects held while strobe high
      if (lcdPins.strobe && (lcdPins.readNotWrite && lcdPins.byteBusOe ||
          stbOld && (rsOld != lcdPins.regSelect ||
          rwOld != lcdPins.readNotWrite)))
        errCnt++;
      busyRd = !lcdPins.regSelect && lcdPins.readNotWrite;
      if (lcdPins.strobe && !stbOld)
      begin
        // no transfer before power-up, nor while busy other than a busy-flag read
        if (upCnt < POWER_CYC || (busyCnt > 0 && !busyRd))
          errCnt++;
        // busy flag with address, or byte of memory set last
        outByte = busyRd ? {busyCnt > 0, addrCnt}
                : selGlyph ? glyphMem[addrCnt[5:0]] : dispMem[addrCnt];
      end
      if (!lcdPins.strobe && stbOld && !busyRd)
      begin
        b = lcdPins.byteBusOut;
        busyCnt = SHORT_CYC;
        if (rsOld)
        begin
          // capture at falling strobe, then advance address
          if (!rwOld && selGlyph)
            glyphMem[addrCnt[5:0]] = b;
          else if (!rwOld)
            dispMem[addrCnt] = b;
          if (shiftEntry && !selGlyph)
            ofs += incMode ? 1 : -1;
          addrCnt = stepAdr(addrCnt, incMode, selGlyph);
        end
        else
        begin
          if (instCnt < 4)
            initLog[instCnt] = b;
          instCnt++;
          if (b[7] || b[6])
          begin
            selGlyph = !b[7];
            addrCnt = b[7] ? b[6:0] : {1'b0, b[5:0]};
          end
          else if (b[5])
            funcReg = b;
          else if (b[4] && b[3])
            ofs += b[2] ? -1 : 1;
          else if (b[4])
            addrCnt = stepAdr(addrCnt, b[2], selGlyph);
          else if (b[3])
            ctlReg = b;
          else if (b[2])
            {incMode, shiftEntry} = b[1:0];
          // clear blanks memory; both home the address
          else if (b[1] || b[0])
          begin
            if (!b[1])
              for (int i = 0; i < 128; i++)
                dispMem[i] = 8'h20;
            if (!b[1])
              incMode = 1'b1;
            addrCnt = 7'h00;
            selGlyph = 1'b0;
            ofs = 0;
            busyCnt = LONG_CYC;
          end
        end
      end
      stbOld = lcdPins.strobe;
      rsOld = lcdPins.regSelect;
      rwOld = lcdPins.readNotWrite;
    end
  end
endmodule

/* tb/clh_host_tb.sv */
// Self-checking bench for the display host, display model on the far side.
// Assumes shortened start-up and execution counts set below.
`timescale 1ns/100ps
module clh_host_tb;
  import clh_pkg::*;
  logic        sys_clk, sys_rst, regWrite, regRead;
  logic [3:0]  regAddr;
  logic [9:0]  regWrData, regRdData, d;
  logic [7:0]  byteBusIn, v, shadow [128];
  logic [6:0]  a, adrs [8];
  logic [31:0] rnd = 32'hc42c;
  clh_pins_t   lcdPins;
  int          miscompares, samplesChecked;

  clh_host #(.POWER_CYC(200), .SHORT_CYC(20), .LONG_CYC(50)) i_clh_host (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .lcdPins(lcdPins), .byteBusIn(byteBusIn));
  // Model defaults match the shortened counts given to the host
  clh_lcd_model i_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .lcdPins(lcdPins),
    .byteBusIn(byteBusIn));

  ////////////////////////////////////////////////////////////////////////////
  // Xorshift source
  function automatic logic [31:0] nextRnd();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction

  // Compare and count
  task automatic check(logic [7:0] seen, logic [7:0] want);
    samplesChecked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // Verdict and end of run
  task automatic testDone();
    if (miscompares == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Software port cycles
  task automatic wr(logic [3:0] ad, logic [9:0] wd);
    @(posedge sys_clk);
    regAddr <= ad;
    regWrData <= wd;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(logic [3:0] ad, output logic [9:0] rdv);
    @(posedge sys_clk);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rdv = regRdData;
  endtask

  // Poll until idle, bounded
  task automatic waitReady();
    logic [9:0] s;
    for (int n = 0; n < 4000; n++)
    begin
      rd(ADR_STATUS, s);
      if (s[ST_READY] === 1'b1)
        return;
    end
    miscompares++;
    $display("wrong value at %0t: host never idle", $time);
  endtask

  task automatic cmd(logic r, logic s, logic [7:0] b);
    wr(ADR_CMD, clh_cmd_t'{r, s, b});
    waitReady();
  endtask

  // Address counter through a busy read
  task automatic busyAdr(logic [6:0] want);
    cmd(1'b1, 1'b0, 8'h00);
    rd(ADR_RDDATA, d);
    check(d[7:0], {1'b0, want});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #(10 * 90000);
    miscompares++;
    testDone();
  end

  // Main sequence
  initial
  begin
    {regAddr, regWrData, regWrite, regRead} = '0;
    sys_rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    check(lcdPins[11:4], 8'h00);
    check(lcdPins[7:0], 8'h00);
    sys_rst <= 1'b0;
    waitReady();
    check(i_model.initLog[0], OP_FUNC | FUNC_8BIT | FUNC_2LINE);
    check(i_model.initLog[1], OP_DISPCTL | (CONFIG_RST & 8'h07));
    check(i_model.initLog[2], OP_CLEAR);
    check(i_model.initLog[3], OP_ENTRY | ENTRY_INC);
    rd(ADR_CONFIG, d);
    check(d[7:0], CONFIG_RST);
    rd(4'hf, d);
    check(d[7:0], 8'h00);
    // Shadow table written twice, read back in order
    v = 8'(nextRnd());
    wr(ADR_TABLE, {2'b00, v});
    wr(ADR_TABLE, {2'b00, ~v});
    rd(ADR_TABLE, d);
    check(d[7:0], v);
    rd(ADR_TABLE, d);
    check(d[7:0], ~v);
    for (int i = 0; i < 128; i++)
      shadow[i] = 8'h20;
    // Second row writes
    cmd(1'b0, 1'b0, OP_DISPADR | 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(nextRnd());
      shadow[64 + i] = v;
      cmd(1'b0, 1'b1, v);
      check(i_model.dispMem[64 + i], v);
    end
    busyAdr(7'h44);
    // Glyph memory at its top address, then data read back from row two
    v = 8'(nextRnd());
    cmd(1'b0, 1'b0, OP_GLYPHADR | 8'h3f);
    cmd(1'b0, 1'b1, v);
    check(i_model.glyphMem[63], v);
    busyAdr(7'h00);
    cmd(1'b0, 1'b0, OP_DISPADR | 8'h40);
    cmd(1'b1, 1'b1, 8'h00);
    rd(ADR_RDDATA, d);
    check(d[7:0], shadow[64]);
    busyAdr(7'h41);
    // Home keeps contents, clear blanks them
    cmd(1'b0, 1'b0, OP_HOME | 8'h01);
    busyAdr(7'h00);
    cmd(1'b1, 1'b1, 8'h00);
    rd(ADR_RDDATA, d);
    check(d[7:0], shadow[0]);
    cmd(1'b0, 1'b0, OP_CLEAR);
    busyAdr(7'h00);
    check(i_model.dispMem[64], 8'h20);
    // Entry, shift, control and function codes
    cmd(1'b0, 1'b0, OP_ENTRY);
    cmd(1'b0, 1'b0, OP_DISPADR | 8'h45);
    cmd(1'b0, 1'b1, 8'h5a);
    busyAdr(7'h44);
    cmd(1'b0, 1'b0, OP_SHIFT | SHIFT_RIGHT);
    busyAdr(7'h45);
    cmd(1'b0, 1'b0, OP_DISPCTL | CTL_DISP | CTL_CURSOR | CTL_BLINK);
    check(i_model.ctlReg, 8'h0f);
    cmd(1'b0, 1'b0, OP_FUNC | FUNC_8BIT | FUNC_2LINE);
    check(i_model.funcReg, 8'h38);
    cmd(1'b0, 1'b0, OP_ENTRY | ENTRY_INC);
    // Second command while one is pending is dropped
    cmd(1'b0, 1'b0, OP_DISPADR | 8'h20);
    @(posedge sys_clk);
    regAddr <= ADR_CMD;
    regWrData <= clh_cmd_t'{1'b0, 1'b1, 8'h41};
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrData <= clh_cmd_t'{1'b0, 1'b1, 8'h42};
    @(posedge sys_clk);
    regWrite <= 1'b0;
    waitReady();
    check(i_model.dispMem[32], 8'h41);
    check(i_model.dispMem[33], 8'h20);
    for (int i = 0; i < 128; i++)
      shadow[i] = i_model.dispMem[i];
    // Random places on both rows, written then read back
    for (int i = 0; i < 8; i++)
    begin
      a = 7'((nextRnd() % 40) + (rnd[7] ? 64 : 0));
      adrs[i] = a;
      v = 8'(nextRnd());
      shadow[a] = v;
      cmd(1'b0, 1'b0, OP_DISPADR | {1'b0, a});
      cmd(1'b0, 1'b1, v);
    end
    for (int i = 0; i < 8; i++)
    begin
      cmd(1'b0, 1'b0, OP_DISPADR | {1'b0, adrs[i]});
      cmd(1'b1, 1'b1, 8'h00);
      rd(ADR_RDDATA, d);
      check(d[7:0], shadow[adrs[i]]);
    end
    // Whole display shifted right moves each row start one column on
    check(i_model.shown(1, 0), shadow[64]);
    cmd(1'b0, 1'b0, OP_SHIFT | SHIFT_DISP | SHIFT_RIGHT);
    check(i_model.shown(1, 1), shadow[64]);
    check(i_model.shown(0, 1), shadow[0]);
    check(8'(i_model.errCnt), 8'h00);
    testDone();
  end
endmodule
